// file: pkg/cpu_irq_seq_consts.svh
// constants of the interrupt sequencer: register offsets, field positions, reset values, cycle counts
// assumes a 32-bit apb register bus with byte addresses
`ifndef CPU_IRQ_SEQ_CONSTS_SVH
`define CPU_IRQ_SEQ_CONSTS_SVH

`define ISQ_PC_W         14
`define ISQ_NSRC         16
`define ISQ_OFF_CTRL     8'h00
`define ISQ_OFF_EXTMASK  8'h04
`define ISQ_OFF_TMRMASK  8'h08
`define ISQ_OFF_EXTFLAG  8'h0c
`define ISQ_OFF_TMRFLAG  8'h10
`define ISQ_OFF_LVLSEL   8'h14
`define ISQ_OFF_EVTSTAT  8'h18
`define ISQ_OFF_EVTMASK  8'h1c
`define ISQ_OFF_SEQSTAT  8'h20
`define ISQ_CTRL_GIE     0
`define ISQ_EVT_ENTRY    0
`define ISQ_EVT_RETURN   1
`define ISQ_EVT_WAKE     2
`define ISQ_RST_GIE      1'b0
`define ISQ_RST_MASK     8'h00
`define ISQ_ENTRY_CYC    3'h4
`define ISQ_WAKE_CYC     3'h4
`define ISQ_JUMP_CYC     3'h3
`define ISQ_RET_CYC      3'h4

`endif

// file: pkg/cpu_irq_seq_pkg.sv
// types of the interrupt sequencer: apb carrier, stack commands, sequence states, module state
// assumes cpu_irq_seq_consts.svh is on the include path
`include "cpu_irq_seq_consts.svh"
package cpu_irq_seq_pkg;
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apbReq_s;
	typedef struct packed {
		logic       pushEn;
		logic [7:0] pushByte;
		logic       popEn;
		logic       spInc2;
	} stackOp_s;
	typedef enum logic [4:0] {
		SEQ_IDLE = 5'h01,
		SEQ_WAKE = 5'h02,
		SEQ_PUSH = 5'h04,
		SEQ_JUMP = 5'h08,
		SEQ_RET  = 5'h10
	} seq_e;
	typedef struct packed {
		seq_e                   seq;
		logic [2:0]             cnt;
		logic                   gie;
		logic [7:0]             extMask;
		logic [7:0]             tmrMask;
		logic [7:0]             extFlag;
		logic [7:0]             tmrFlag;
		logic [7:0]             lvlSel;
		logic [2:0]             evtStat;
		logic [2:0]             evtMask;
		logic [`ISQ_PC_W-1:0]   savedPc;
		logic [3:0]             vecIdx;
		logic                   pready;
		logic [31:0]            prdata;
		logic                   pslverr;
		logic                   irq;
		stackOp_s               stack;
		logic                   pcLoad;
		logic [`ISQ_PC_W-1:0]   pcVec;
		logic                   vecJump;
	} seqState_s;
endpackage

// file: rtl/cpu_interrupt_sequencer.sv
// interrupt acceptance, entry and return sequencing for a small 8-bit core
// assumes an apb master for the registers and a core that reports instruction ends, sleep and return
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_irq_seq_consts.svh"
module cpu_interrupt_sequencer #(
	parameter logic [`ISQ_PC_W-1:0] VEC_BASE = 14'h0000
) (
	// clock and reset
	input  wire  logic                           mclk,
	input  wire  logic                           rst,
	// apb slave
	input  wire  cpu_irq_seq_pkg::apbReq_s       apbReq,
	output logic                                 pready,
	output logic [31:0]                          prdata,
	output logic                                 pslverr,
	// peripheral requests
	input  wire  logic [7:0]                     extEvent,
	input  wire  logic [7:0]                     extLevel,
	input  wire  logic [7:0]                     tmrEvent,
	// core side
	input  wire  logic                           instrEnd,
	input  wire  logic                           sleeping,
	input  wire  logic                           retExec,
	input  wire  logic [`ISQ_PC_W-1:0]           pcNow,
	output cpu_irq_seq_pkg::stackOp_s            stackOp,
	output logic                                 pcLoad,
	output logic [`ISQ_PC_W-1:0]                 pcVec,
	output logic                                 vecJump,
	output logic                                 globalEn,
	// event interrupt
	output logic                                 irq
);
	import cpu_irq_seq_pkg::*;

	// vectors are two words apart with slot zero kept for reset
	if (VEC_BASE[0] != 1'b0) begin : gBadBase
		$error("vector base must be word-pair aligned");
	end

	seqState_s st_r;
	seqState_s st_nxt;

	logic [15:0] pendVec;
	logic [4:0]  firstHit;
	logic        anyPend;
	logic [3:0]  winIdx;
	logic        accept;
	logic        apbAcc;
	logic        wrNow;
	logic [7:0]  wByte;

	// lowest set bit gives the lowest vector address
	function automatic logic [4:0] firstSet(input logic [15:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 15; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] rdReg(input seqState_s s, input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			`ISQ_OFF_CTRL:    r = {31'h0, s.gie};
			`ISQ_OFF_EXTMASK: r = {24'h0, s.extMask};
			`ISQ_OFF_TMRMASK: r = {24'h0, s.tmrMask};
			`ISQ_OFF_EXTFLAG: r = {24'h0, s.extFlag};
			`ISQ_OFF_TMRFLAG: r = {24'h0, s.tmrFlag};
			`ISQ_OFF_LVLSEL:  r = {24'h0, s.lvlSel};
			`ISQ_OFF_EVTSTAT: r = {29'h0, s.evtStat};
			`ISQ_OFF_EVTMASK: r = {29'h0, s.evtMask};
			`ISQ_OFF_SEQSTAT: r = {16'h0, s.savedPc[7:0], s.vecIdx, s.cnt[0], 3'(s.seq >> 2)};
			default:          r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= `ISQ_OFF_SEQSTAT);
	endfunction

	always_comb begin
		// a level-sensed source is pending only while its input holds
		pendVec = {st_r.tmrFlag & st_r.tmrMask,
			((st_r.extFlag & ~st_r.lvlSel) | (extLevel & st_r.lvlSel)) & st_r.extMask};
		firstHit = firstSet(pendVec);
		anyPend  = firstHit[4];
		winIdx   = firstHit[3:0];
		// the return sequence is not an instruction end, so one main instruction runs first unless the core is sleeping
		accept  = (st_r.seq == SEQ_IDLE) && st_r.gie && anyPend && (instrEnd || sleeping);
		apbAcc  = apbReq.psel && apbReq.penable && !st_r.pready;
		wrNow   = apbReq.psel && apbReq.penable && st_r.pready && apbReq.pwrite && mapped(apbReq.paddr);
		wByte   = apbReq.pwdata[7:0];
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.pready        = apbAcc;
		st_nxt.pslverr       = apbAcc && !mapped(apbReq.paddr);
		st_nxt.prdata        = apbAcc ? rdReg(st_r, apbReq.paddr) : 32'h0000_0000;
		st_nxt.stack         = '0;
		st_nxt.pcLoad        = 1'b0;
		st_nxt.vecJump       = 1'b0;

		// software writes land on the edge where pready is seen high
		if (wrNow) begin
			case (apbReq.paddr)
				`ISQ_OFF_CTRL:    st_nxt.gie     = wByte[`ISQ_CTRL_GIE];
				`ISQ_OFF_EXTMASK: st_nxt.extMask = wByte;
				`ISQ_OFF_TMRMASK: st_nxt.tmrMask = wByte;
				`ISQ_OFF_EXTFLAG: st_nxt.extFlag = st_r.extFlag & ~wByte;
				`ISQ_OFF_TMRFLAG: st_nxt.tmrFlag = st_r.tmrFlag & ~wByte;
				`ISQ_OFF_LVLSEL:  st_nxt.lvlSel  = wByte;
				`ISQ_OFF_EVTSTAT: st_nxt.evtStat = st_r.evtStat & ~wByte[2:0];
				`ISQ_OFF_EVTMASK: st_nxt.evtMask = wByte[2:0];
				default:          st_nxt.lvlSel  = st_nxt.lvlSel;
			endcase
		end

		case (st_r.seq)
			SEQ_IDLE: begin
				st_nxt.cnt = 3'h0;
				if (accept) begin
					st_nxt.gie     = 1'b0;
					st_nxt.vecIdx  = winIdx;
					st_nxt.savedPc = pcNow;
					st_nxt.seq     = sleeping ? SEQ_WAKE : SEQ_PUSH;
					st_nxt.evtStat[`ISQ_EVT_ENTRY] = 1'b1;
					st_nxt.evtStat[`ISQ_EVT_WAKE]  = st_nxt.evtStat[`ISQ_EVT_WAKE] | sleeping;
				end else if (retExec) begin
					st_nxt.seq = SEQ_RET;
				end
			end
			SEQ_WAKE: begin
				st_nxt.cnt = st_r.cnt + 3'h1;
				if (st_r.cnt == `ISQ_WAKE_CYC - 3'h1) begin
					st_nxt.cnt = 3'h0;
					st_nxt.seq = SEQ_PUSH;
				end
			end
			SEQ_PUSH: begin
				st_nxt.cnt = st_r.cnt + 3'h1;
				// low byte first, then the upper six bits of the 14-bit counter
				if (st_r.cnt == 3'h0) begin
					st_nxt.stack.pushEn   = 1'b1;
					st_nxt.stack.pushByte = st_r.savedPc[7:0];
				end else if (st_r.cnt == 3'h1) begin
					st_nxt.stack.pushEn   = 1'b1;
					st_nxt.stack.pushByte = {2'h0, st_r.savedPc[13:8]};
				end else if (st_r.cnt == `ISQ_ENTRY_CYC - 3'h1) begin
					st_nxt.cnt    = 3'h0;
					st_nxt.seq    = SEQ_JUMP;
					st_nxt.pcLoad = 1'b1;
					// the jump indication covers all three jump cycles, starting with the load
					st_nxt.vecJump = 1'b1;
					st_nxt.pcVec  = VEC_BASE + {9'h0, st_r.vecIdx, 1'b0} + 14'h0002;
					if (st_r.vecIdx[3]) begin
						st_nxt.tmrFlag[st_r.vecIdx[2:0]] = 1'b0;
					end else begin
						st_nxt.extFlag[st_r.vecIdx[2:0]] = 1'b0;
					end
				end
			end
			SEQ_JUMP: begin
				st_nxt.vecJump = 1'b1;
				st_nxt.cnt     = st_r.cnt + 3'h1;
				if (st_r.cnt == `ISQ_JUMP_CYC - 3'h1) begin
					st_nxt.vecJump = 1'b0;
					st_nxt.cnt     = 3'h0;
					st_nxt.seq     = SEQ_IDLE;
				end
			end
			SEQ_RET: begin
				st_nxt.cnt = st_r.cnt + 3'h1;
				// the core flags register is left untouched on both entry and return
				if (st_r.cnt <= 3'h1) begin
					st_nxt.stack.popEn = 1'b1;
				end else if (st_r.cnt == 3'h2) begin
					st_nxt.stack.spInc2 = 1'b1;
				end else begin
					st_nxt.cnt = 3'h0;
					st_nxt.gie = 1'b1;
					st_nxt.seq = SEQ_IDLE;
					st_nxt.evtStat[`ISQ_EVT_RETURN] = 1'b1;
				end
			end
			default: begin
				st_nxt.seq = SEQ_IDLE;
				st_nxt.cnt = 3'h0;
			end
		endcase

		// new events win over any clear in the same cycle; level sources never latch
		// masked with the new select so a flag cannot outlive a switch to level sensing
		st_nxt.extFlag = (st_nxt.extFlag | extEvent) & ~st_nxt.lvlSel;
		st_nxt.tmrFlag = st_nxt.tmrFlag | tmrEvent;
		st_nxt.irq     = |(st_nxt.evtStat & st_nxt.evtMask);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_r         <= '0;
			st_r.seq     <= SEQ_IDLE;
			st_r.gie     <= `ISQ_RST_GIE;
			st_r.extMask <= `ISQ_RST_MASK;
			st_r.tmrMask <= `ISQ_RST_MASK;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pready   = st_r.pready;
	assign prdata   = st_r.prdata;
	assign pslverr  = st_r.pslverr;
	assign stackOp  = st_r.stack;
	assign pcLoad   = st_r.pcLoad;
	assign pcVec    = st_r.pcVec;
	assign vecJump  = st_r.vecJump;
	assign globalEn = st_r.gie;
	assign irq      = st_r.irq;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence sPush4;
		(st_r.seq == SEQ_PUSH) [*4] ##1 (st_r.seq == SEQ_JUMP && st_r.pcLoad);
	endsequence
	sequence sRet4;
		(st_r.seq == SEQ_RET) [*4] ##1 (st_r.seq == SEQ_IDLE && st_r.gie);
	endsequence

	AST_ACCEPT_CLEARS_GIE: assert property (accept |=> !st_r.gie)
		else $error("global enable still set after accept");
	AST_ENTRY_FOUR: assert property (accept && !sleeping |=> sPush4)
		else $error("entry did not take four cycles");
	AST_WAKE_EXTRA: assert property (accept && sleeping |=> (st_r.seq == SEQ_WAKE) [*4] ##1 sPush4)
		else $error("wake did not add four cycles");
	AST_JUMP_THREE: assert property ($rose(st_r.vecJump) |-> st_r.vecJump [*3] ##1 (st_r.seq == SEQ_IDLE))
		else $error("vector jump not three cycles");
	AST_RET_FOUR: assert property (st_r.seq == SEQ_IDLE && !accept && retExec |=> sRet4)
		else $error("return sequence wrong");
	AST_RET_STACK: assert property ($rose(st_r.seq == SEQ_RET) |=> stackOp.popEn ##1 stackOp.popEn ##1 stackOp.spInc2)
		else $error("return did not pop two bytes and bump the pointer");
	AST_VEC_CLEARS: assert property (st_nxt.pcLoad && !st_r.vecIdx[3] && !extEvent[st_r.vecIdx[2:0]]
		|=> !st_r.extFlag[st_r.vecIdx[2:0]])
		else $error("served flag not cleared");
	AST_EVENT_SETS: assert property (tmrEvent[0] |=> st_r.tmrFlag[0])
		else $error("timer event did not set its flag");
	AST_LEVEL_NOFLAG: assert property ((st_r.extFlag & st_r.lvlSel) == 8'h00)
		else $error("level source holds a flag");
	AST_INSTR_END: assert property ((st_r.seq == SEQ_IDLE) ##1 (st_r.seq == SEQ_PUSH || st_r.seq == SEQ_WAKE)
		|-> $past(instrEnd) || $past(sleeping))
		else $error("entry started mid instruction");
	AST_PRIORITY: assert property (accept && pendVec[2] |=> st_r.vecIdx <= 4'h2)
		else $error("lowest vector not chosen");
endmodule
`default_nettype wire

// file: verif/core_model.sv
// core stand-in: program counter and byte stack worked by the sequencer
// assumes one clock and the synchronous reset shared with the sequencer
`timescale 1ns/1ps
`default_nettype none
`include "cpu_irq_seq_consts.svh"
module core_model (
	// clock and reset
	input  wire logic                      mclk,
	input  wire logic                      rst,
	// sequencer side
	input  wire cpu_irq_seq_pkg::stackOp_s stackOp,
	input  wire logic                      pcLoad,
	input  wire logic [`ISQ_PC_W-1:0]      pcVec,
	// observation
	output logic [`ISQ_PC_W-1:0]           pcNow,
	output logic [7:0]                     sp,
	output logic [15:0]                    pushLog
);
	import cpu_irq_seq_pkg::*;
	// both pc bytes differ so a swapped push order shows
	localparam logic [`ISQ_PC_W-1:0] MAIN_PC = 14'h2a5c;
	always_ff @(posedge mclk) begin
		if (rst) begin
			pcNow   <= MAIN_PC;
			sp      <= 8'hff;
			pushLog <= 16'h0000;
		end else begin
			if (pcLoad) begin
				pcNow <= pcVec;
			end
			if (stackOp.pushEn) begin
				pushLog <= {pushLog[7:0], stackOp.pushByte};
			end
			// pops move no pointer; only pushes and the add-two pulse do, so a missing pulse shows
			sp <= sp - {7'h00, stackOp.pushEn} + (stackOp.spInc2 ? 8'h02 : 8'h00);
		end
	end
endmodule
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench: apb tasks, entry and return sequences against a core stand-in
// assumes the package, the sequencer and core_model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "cpu_irq_seq_consts.svh"
`define CHK(n,e,g) begin checks++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module testbench;
	import cpu_irq_seq_pkg::*;
	localparam logic [13:0] VB = 14'h0100;
	logic             mclk     = 1'b0;
	logic             rst      = 1'b1;
	apbReq_s          apbReq   = '0;
	logic [7:0]       extEvent = 8'h00;
	logic [7:0]       extLevel = 8'h00;
	logic [7:0]       tmrEvent = 8'h00;
	logic             instrEnd = 1'b0;
	logic             sleeping = 1'b0;
	logic             retExec  = 1'b0;
	logic             pready, pslverr, pcLoad, vecJump, globalEn, irq, err;
	logic [31:0]      prdata, rd;
	logic [13:0]      pcNow, pcVec;
	logic [7:0]       sp;
	logic [15:0]      pushLog;
	stackOp_s         stackOp;
	int               fails  = 0;
	int               checks = 0;
	always #2 mclk = ~mclk;
	cpu_interrupt_sequencer #(.VEC_BASE(VB)) uut (
		.mclk(mclk), .rst(rst), .apbReq(apbReq), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.extEvent(extEvent), .extLevel(extLevel), .tmrEvent(tmrEvent), .instrEnd(instrEnd),
		.sleeping(sleeping), .retExec(retExec), .pcNow(pcNow), .stackOp(stackOp), .pcLoad(pcLoad),
		.pcVec(pcVec), .vecJump(vecJump), .globalEn(globalEn), .irq(irq));
	core_model core (.mclk(mclk), .rst(rst), .stackOp(stackOp), .pcLoad(pcLoad), .pcVec(pcVec),
		.pcNow(pcNow), .sp(sp), .pushLog(pushLog));
	task automatic test_done();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic limit(input int i);
		if (i >= 40) begin
			fails++;
			test_done();
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge mclk);
		apbReq <= '{1'b1, 1'b0, w, a, d};
		@(posedge mclk);
		apbReq.penable <= 1'b1;
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (pready !== 1'b1 && i < 40);
		rd = prdata;
		err = pslverr;
		apbReq <= '0;
		limit(i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(nm, e, rd);
	endtask
	task automatic pulse(input logic [7:0] e, input logic [7:0] t);
		extEvent <= e;
		tmrEvent <= t;
		@(posedge mclk);
		extEvent <= 8'h00;
		tmrEvent <= 8'h00;
		@(posedge mclk);
	endtask
	// counts are taken on the edge after the registered output rose, hence one more than the rule
	task automatic enter(input logic slp, input int expN, input logic [13:0] expVec, input logic [15:0] expPush);
		int i;
		if (slp) begin
			sleeping <= 1'b1;
		end else begin
			instrEnd <= 1'b1;
		end
		@(posedge mclk);
		instrEnd <= 1'b0;
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (pcLoad !== 1'b1 && i < 40);
		sleeping <= 1'b0;
		limit(i);
		`CHK("entry cycles", expN, i);
		`CHK("vector", expVec, pcVec);
		`CHK("enable after accept", 1'b0, globalEn);
		`CHK("jump start", 1'b1, vecJump);
		repeat (2) @(posedge mclk);
		`CHK("jump third cycle", 1'b1, vecJump);
		@(posedge mclk);
		`CHK("jump over", 1'b0, vecJump);
		`CHK("pushed pc", expPush, pushLog);
	endtask
	task automatic ret(input logic [7:0] expSp);
		int i;
		retExec <= 1'b1;
		@(posedge mclk);
		retExec <= 1'b0;
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (globalEn !== 1'b1 && i < 40);
		limit(i);
		`CHK("return cycles", 5, i);
		`CHK("stack pointer", expSp, sp);
	endtask
	initial begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		rdchk("ctrl", `ISQ_OFF_CTRL, 32'h0);
		wr(`ISQ_OFF_EXTMASK, 32'hffffffff);
		rdchk("ext mask", `ISQ_OFF_EXTMASK, 32'hff);
		rdchk("timer mask", `ISQ_OFF_TMRMASK, 32'h0);
		apb(1'b0, 8'h44, 32'h0);
		`CHK("unmapped", 1'b1, err);
		$display("test 1 done");
		wr(`ISQ_OFF_EXTMASK, 32'h0);
		pulse(8'h0c, 8'h01);
		rdchk("ext flags", `ISQ_OFF_EXTFLAG, 32'h0c);
		rdchk("timer flags", `ISQ_OFF_TMRFLAG, 32'h01);
		wr(`ISQ_OFF_EXTFLAG, 32'h0);
		rdchk("flags kept", `ISQ_OFF_EXTFLAG, 32'h0c);
		wr(`ISQ_OFF_EXTFLAG, 32'h04);
		rdchk("flag cleared", `ISQ_OFF_EXTFLAG, 32'h08);
		$display("test 2 done");
		wr(`ISQ_OFF_EVTMASK, 32'h1);
		wr(`ISQ_OFF_EXTMASK, 32'h04);
		wr(`ISQ_OFF_TMRMASK, 32'h01);
		pulse(8'h04, 8'h00);
		wr(`ISQ_OFF_CTRL, 32'h1);
		repeat (4) @(posedge mclk);
		`CHK("no accept mid instruction", 1'b1, globalEn);
		enter(1'b0, 5, VB + 14'h6, 16'h5c2a);
		`CHK("entry irq", 1'b1, irq);
		rdchk("vectored flag", `ISQ_OFF_EXTFLAG, 32'h08);
		wr(`ISQ_OFF_EVTSTAT, 32'h1);
		wr(`ISQ_OFF_EVTMASK, 32'h0);
		`CHK("irq cleared", 1'b0, irq);
		ret(8'hff);
		repeat (3) @(posedge mclk);
		`CHK("one instruction first", 1'b1, globalEn);
		enter(1'b0, 5, VB + 14'h12, 16'h0601);
		`CHK("masked irq", 1'b0, irq);
		$display("test 3 done");
		wr(`ISQ_OFF_EXTMASK, 32'h0c);
		wr(`ISQ_OFF_CTRL, 32'h1);
		enter(1'b0, 5, VB + 14'h8, 16'h1201);
		ret(8'hfd);
		wr(`ISQ_OFF_CTRL, 32'h0);
		ret(8'hff);
		pulse(8'h04, 8'h00);
		enter(1'b1, 9, VB + 14'h6, 16'h0801);
		ret(8'hff);
		$display("test 4 done");
		wr(`ISQ_OFF_LVLSEL, 32'h02);
		wr(`ISQ_OFF_EXTMASK, 32'h02);
		pulse(8'h02, 8'h00);
		extLevel <= 8'h02;
		rdchk("level no flag", `ISQ_OFF_EXTFLAG, 32'h0);
		enter(1'b0, 5, VB + 14'h4, 16'h0601);
		extLevel <= 8'h00;
		ret(8'hff);
		instrEnd <= 1'b1;
		@(posedge mclk);
		instrEnd <= 1'b0;
		repeat (4) @(posedge mclk);
		`CHK("level gone", 1'b1, globalEn);
		$display("test 5 done");
		test_done();
	end
endmodule
`default_nettype wire
